/* hw/srm_pkg.sv */
// constants and types of the scan reading memory block
package srm_pkg;
  localparam int NCH = 8;
  localparam int CHW = 3;
  localparam int RDW = 32;
  localparam int TSW = 48;
  localparam int AW = 17;
  localparam int MEM_DEPTH = 32'h000186A0;
  localparam int MW = CHW + TSW + RDW;
  localparam int OWW = MW + 1;
  localparam int FDEPTH = 16;
  localparam int NALM = 4;
  localparam int QW = 16;
  localparam int QOVF_BIT = 12;
  localparam int SUMW = 64;
  localparam int SQW = 96;
  localparam int CNTW = 32;
  // time stamp resolution is one millisecond
  localparam int CLK_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam logic signed [31:0] LIM_LO_DEF = 32'hFFFFFFFF;
  localparam logic signed [31:0] LIM_HI_DEF = 32'h00000001;
  localparam logic signed [31:0] LIM_MIN = 32'hB8797400;
  localparam logic signed [31:0] LIM_MAX = 32'h47868C00;
  localparam logic [7:0] HDR_HASH = 8'h23;
  localparam logic [7:0] HDR_TWO = 8'h32;
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [6:0] HDR_LEN_MAX = 7'h63;
  localparam logic [6:0] HDR_TEN = 7'h0A;
  localparam logic [AW-1:0] HDR_RD_MAX = 17'h00006;
  localparam logic [1:0] UNIT_C = 2'h0;
  localparam logic [1:0] UNIT_F = 2'h1;
  localparam logic [1:0] UNIT_K = 2'h2;
  typedef enum logic [2:0] {
    TRG_IDLE = 3'h1,
    TRG_WAIT = 3'h2,
    TRG_RUN = 3'h4
  } srm_trg_t;
  typedef enum logic [3:0] {
    ENG_IDLE = 4'h1,
    ENG_HDR = 4'h2,
    ENG_RD = 4'h4,
    ENG_PUSH = 4'h8
  } srm_eng_t;
endpackage

/* hw/srm_fifo.sv */
// valid/ready fifo for the readout stream
`timescale 1ns/1ps
module srm_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic in_vld_i,
  output logic in_rdy_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_vld_o,
  input wire logic out_rdy_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [PW:0] cnt_ff;
  logic wr_w;
  logic rd_w;
  assign in_rdy_o = cnt_ff != FULL;
  assign out_vld_o = cnt_ff != '0;
  assign wr_w = in_vld_i & in_rdy_o;
  assign rd_w = out_vld_o & out_rdy_i;
  assign out_data_o = mem_ff[rp_ff];
  // depth is a power of two, pointers wrap naturally
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= '0;
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (wr_w) mem_ff[wp_ff] <= in_data_i;
      if (wr_w) wp_ff <= wp_ff + 1'b1;
      if (rd_w) rp_ff <= rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (PW+1)'(wr_w) - (PW+1)'(rd_w);
    end
  end
endmodule // srm_fifo

/* hw/srm_scan_mem.sv */
// scan control, reading memory, statistics and alarms
`timescale 1ns/1ps
module srm_scan_mem #(
  parameter int MS_CYC_P = srm_pkg::MS_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic cmd_abort_i,
  input wire logic cmd_arm_i,
  input wire logic cmd_fetch_i,
  input wire logic cmd_read_i,
  input wire logic cmd_remove_i,
  input wire logic rm_all_i,
  input wire logic [srm_pkg::AW-1:0] rm_cnt_i,
  input wire logic trig_src_wr_i,
  input wire logic trig_src_ext_i,
  input wire logic trg_bus_i,
  input wire logic trig_pin_i,
  input wire logic meas_vld_i,
  input wire logic [srm_pkg::CHW-1:0] meas_ch_i,
  input wire logic signed [srm_pkg::RDW-1:0] meas_data_i,
  input wire logic scan_end_i,
  input wire logic cfg_wr_i,
  input wire logic [srm_pkg::CHW-1:0] cfg_ch_i,
  input wire logic cfg_temp_i,
  input wire logic unit_wr_i,
  input wire logic [srm_pkg::CHW-1:0] unit_ch_i,
  input wire logic [1:0] unit_i,
  input wire logic lim_wr_i,
  input wire logic lim_en_wr_i,
  input wire logic lim_upper_i,
  input wire logic [srm_pkg::CHW-1:0] lim_ch_i,
  input wire logic signed [srm_pkg::RDW-1:0] lim_val_i,
  input wire logic lim_en_i,
  input wire logic meter_set_i,
  input wire logic meter_val_i,
  input wire logic st_clr_i,
  input wire logic [srm_pkg::NCH-1:0] st_clr_mask_i,
  input wire logic [srm_pkg::CHW-1:0] st_ch_i,
  output logic out_vld_o,
  input wire logic out_rdy_i,
  output logic [srm_pkg::OWW-1:0] out_data_o,
  output logic [2:0] trg_state_o,
  output logic busy_o,
  output logic [srm_pkg::AW-1:0] mem_count_o,
  output logic [srm_pkg::QW-1:0] ques_cond_o,
  output logic err_o,
  output logic meter_on_o,
  output logic fact_rst_o,
  output logic [srm_pkg::NALM-1:0] alarm_o,
  output logic signed [srm_pkg::SUMW-1:0] st_sum_o,
  output logic [srm_pkg::SQW-1:0] st_sq_o,
  output logic [srm_pkg::CNTW-1:0] st_cnt_o,
  output logic signed [srm_pkg::RDW-1:0] st_min_o,
  output logic signed [srm_pkg::RDW-1:0] st_max_o,
  output logic [srm_pkg::RDW-1:0] st_ptp_o,
  output logic [srm_pkg::TSW-1:0] st_min_ts_o,
  output logic [srm_pkg::TSW-1:0] st_max_ts_o,
  output logic [1:0] st_unit_o
);
  localparam int AW = srm_pkg::AW;
  localparam int NCH = srm_pkg::NCH;
  localparam logic [AW-1:0] DEPTH = AW'(srm_pkg::MEM_DEPTH);

  function automatic logic [AW-1:0] nxt_addr(input logic [AW-1:0] a);
    nxt_addr = (a == DEPTH - 1'b1) ? '0 : a + 1'b1;
  endfunction

  function automatic logic hit(input logic [srm_pkg::CHW-1:0] c, input int i);
    hit = c == srm_pkg::CHW'(i);
  endfunction

  srm_pkg::srm_trg_t trg_ff;
  srm_pkg::srm_trg_t nxt_trg;
  srm_pkg::srm_eng_t eng_ff;
  srm_pkg::srm_eng_t nxt_eng;
  logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic trig_src_ff, meter_on_ff, frst_ff, err_ff, ovf_ff, fpend_ff, dest_ff;
  logic [31:0] div_ff;
  logic [srm_pkg::TSW-1:0] ts_ff;
  logic [srm_pkg::MW-1:0] mem_ff [srm_pkg::MEM_DEPTH];
  logic [srm_pkg::MW-1:0] buf_ff;
  logic [AW-1:0] wp_ff, rp_ff, cnt_ff, fp_ff, left_ff;
  logic [6:0] hlen_ff;
  logic [NCH-1:0] temp_ff, alm_ff;
  logic [srm_pkg::NALM-1:0] alarm_ff;
  logic [1:0] unit_ff [NCH];
  logic signed [srm_pkg::SUMW-1:0] sum_ff [NCH];
  logic [srm_pkg::SQW-1:0] sq_ff [NCH];
  logic [srm_pkg::CNTW-1:0] cnt_c_ff [NCH];
  logic signed [srm_pkg::RDW-1:0] min_ff [NCH];
  logic signed [srm_pkg::RDW-1:0] max_ff [NCH];
  logic [srm_pkg::TSW-1:0] min_ts_ff [NCH];
  logic [srm_pkg::TSW-1:0] max_ts_ff [NCH];
  logic signed [srm_pkg::SUMW-1:0] st_sum_ff;
  logic [srm_pkg::SQW-1:0] st_sq_ff;
  logic [srm_pkg::CNTW-1:0] st_cnt_ff;
  logic signed [srm_pkg::RDW-1:0] st_min_ff, st_max_ff;
  logic [srm_pkg::RDW-1:0] st_ptp_ff;
  logic [srm_pkg::TSW-1:0] st_min_ts_ff, st_max_ts_ff;
  logic [1:0] st_unit_ff;

  // pin trigger synchroniser and edge
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= trig_pin_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  wire idle_w = trg_ff == srm_pkg::TRG_IDLE;
  wire run_w = trg_ff == srm_pkg::TRG_RUN;
  wire trig_hit_w = trig_src_ff ? (pin_s2_ff & ~pin_s3_ff) : trg_bus_i;
  wire frst_w = meter_set_i & (meter_val_i != meter_on_ff);
  wire arm_req_w = cmd_arm_i | cmd_read_i;
  wire arm_w = arm_req_w & idle_w & ~cmd_abort_i & ~frst_w;
  wire clr_all_w = arm_w | frst_w;
  wire cfg_try_w = cfg_wr_i | trig_src_wr_i | unit_wr_i;
  wire cfg_ok_w = cfg_wr_i & idle_w;
  wire unit_ok_w = unit_wr_i & idle_w & temp_ff[unit_ch_i];
  wire lim_bad_w = lim_wr_i & (lim_val_i < srm_pkg::LIM_MIN | lim_val_i > srm_pkg::LIM_MAX);
  wire lim_ok_w = lim_wr_i & ~lim_bad_w;
  wire err_w = (cfg_try_w & ~idle_w) | (unit_wr_i & ~temp_ff[unit_ch_i]) | lim_bad_w
               | (arm_req_w & ~idle_w);

  // trigger sequencing
  always_comb begin
    nxt_trg = trg_ff;
    if (cmd_abort_i | frst_w) begin
      nxt_trg = srm_pkg::TRG_IDLE;
    end else begin
      case (trg_ff)
        srm_pkg::TRG_IDLE: if (arm_w) nxt_trg = srm_pkg::TRG_WAIT;
        srm_pkg::TRG_WAIT: if (trig_hit_w) nxt_trg = srm_pkg::TRG_RUN;
        srm_pkg::TRG_RUN: if (scan_end_i) nxt_trg = srm_pkg::TRG_IDLE;
        default: nxt_trg = srm_pkg::TRG_IDLE;
      endcase
    end
  end

  // control and status flops
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trg_ff <= srm_pkg::TRG_IDLE;
      trig_src_ff <= 1'b0;
      meter_on_ff <= 1'b0;
      frst_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      trg_ff <= nxt_trg;
      if (trig_src_wr_i & idle_w) trig_src_ff <= trig_src_ext_i;
      if (frst_w) trig_src_ff <= 1'b0;
      if (meter_set_i) meter_on_ff <= meter_val_i;
      frst_ff <= frst_w;
      err_ff <= err_w;
    end
  end

  // millisecond time base for stamps
  wire tick_w = div_ff == 32'(MS_CYC_P - 1);
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_ff <= '0;
      ts_ff <= '0;
    end else begin
      div_ff <= tick_w ? '0 : div_ff + 1'b1;
      if (tick_w) ts_ff <= ts_ff + 1'b1;
    end
  end

  // circular reading memory
  wire full_w = cnt_ff == DEPTH;
  wire we_w = meas_vld_i & run_w;
  wire ovw_w = we_w & full_w;
  wire push_req_w = (eng_ff == srm_pkg::ENG_HDR) | ((eng_ff == srm_pkg::ENG_PUSH) & ~ovw_w);
  wire f_rdy_w;
  wire push_w = push_req_w & f_rdy_w;
  wire pop_w = push_w & dest_ff & (eng_ff == srm_pkg::ENG_PUSH);

  always_ff @(posedge mclk_i) begin
    if (we_w) mem_ff[wp_ff] <= {meas_ch_i, ts_ff, meas_data_i};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else if (clr_all_w) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (we_w) wp_ff <= nxt_addr(wp_ff);
      if (ovw_w | pop_w) rp_ff <= nxt_addr(rp_ff);
      if (we_w & ~full_w & ~pop_w) cnt_ff <= cnt_ff + 1'b1;
      else if (pop_w & ~we_w) cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) ovf_ff <= 1'b0;
    else if (ovw_w) ovf_ff <= 1'b1;
    else if (clr_all_w) ovf_ff <= 1'b0;
  end

  // readout engine
  wire rm_take_w = cmd_remove_i & (eng_ff == srm_pkg::ENG_IDLE) & ~clr_all_w;
  wire fst_w = fpend_ff & idle_w & (eng_ff == srm_pkg::ENG_IDLE) & ~rm_take_w & ~clr_all_w;
  wire [AW-1:0] rm_n_w = (rm_all_i | rm_cnt_i == '0 | rm_cnt_i > cnt_ff) ? cnt_ff
                         : rm_cnt_i;
  wire [6:0] len_w = (rm_n_w == '0) ? 7'h00 : (rm_n_w > srm_pkg::HDR_RD_MAX)
                     ? srm_pkg::HDR_LEN_MAX : {rm_n_w[2:0], 4'h0} - 7'h01;
  wire [6:0] tens_w = hlen_ff / srm_pkg::HDR_TEN;
  wire [6:0] ones_w = hlen_ff - 7'(tens_w * srm_pkg::HDR_TEN);
  wire [31:0] hdr_w = {srm_pkg::HDR_HASH, srm_pkg::HDR_TWO,
                       srm_pkg::ASC_ZERO + {1'b0, tens_w}, srm_pkg::ASC_ZERO + {1'b0, ones_w}};
  wire [srm_pkg::OWW-1:0] fin_w = (eng_ff == srm_pkg::ENG_HDR)
                                  ? {1'b1, {(srm_pkg::OWW - 33){1'b0}}, hdr_w}
                                  : {1'b0, buf_ff};

  always_comb begin
    nxt_eng = eng_ff;
    case (eng_ff)
      srm_pkg::ENG_IDLE: begin
        if (rm_take_w) nxt_eng = srm_pkg::ENG_HDR;
        else if (fst_w && cnt_ff != '0) nxt_eng = srm_pkg::ENG_RD;
      end
      srm_pkg::ENG_HDR: if (f_rdy_w) nxt_eng = (left_ff == '0) ? srm_pkg::ENG_IDLE
                                                            : srm_pkg::ENG_RD;
      srm_pkg::ENG_RD: if (!ovw_w) nxt_eng = srm_pkg::ENG_PUSH;
      srm_pkg::ENG_PUSH: if (push_w) nxt_eng = (left_ff == 17'h00001) ? srm_pkg::ENG_IDLE
                                                                    : srm_pkg::ENG_RD;
      default: nxt_eng = srm_pkg::ENG_IDLE;
    endcase
    if (clr_all_w) nxt_eng = srm_pkg::ENG_IDLE;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      eng_ff <= srm_pkg::ENG_IDLE;
      left_ff <= '0;
      fp_ff <= '0;
      dest_ff <= 1'b0;
      hlen_ff <= '0;
      buf_ff <= '0;
    end else begin
      eng_ff <= nxt_eng;
      if (rm_take_w) begin
        left_ff <= rm_n_w;
        dest_ff <= 1'b1;
        hlen_ff <= len_w;
      end else if (fst_w) begin
        left_ff <= cnt_ff;
        fp_ff <= rp_ff;
        dest_ff <= 1'b0;
      end
      if (eng_ff == srm_pkg::ENG_RD) buf_ff <= mem_ff[dest_ff ? rp_ff : fp_ff];
      if (pop_w | (push_w & eng_ff == srm_pkg::ENG_PUSH)) left_ff <= left_ff - 1'b1;
      if (push_w & ~dest_ff & eng_ff == srm_pkg::ENG_PUSH) fp_ff <= nxt_addr(fp_ff);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) fpend_ff <= 1'b0;
    else if (cmd_fetch_i | (cmd_read_i & arm_w)) fpend_ff <= 1'b1;
    else if (fst_w) fpend_ff <= 1'b0;
  end

  srm_fifo #(
    .W(srm_pkg::OWW),
    .DEPTH(srm_pkg::FDEPTH)
  ) u_ofifo (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .in_vld_i(push_req_w),
    .in_rdy_o(f_rdy_w),
    .in_data_i(fin_w),
    .out_vld_o(out_vld_o),
    .out_rdy_i(out_rdy_i),
    .out_data_o(out_data_o)
  );

  // per channel settings, statistics and alarms
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    wire mh_w = we_w & hit(meas_ch_i, g);
    wire sclr_w = clr_all_w | (st_clr_i & st_clr_mask_i[g]);
    wire first_w = sclr_w | (cnt_c_ff[g] == '0);
    logic signed [srm_pkg::RDW-1:0] lo_ff, hi_ff;
    logic lo_en_ff, hi_en_ff;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        temp_ff[g] <= 1'b0;
        unit_ff[g] <= srm_pkg::UNIT_C;
        lo_ff <= srm_pkg::LIM_LO_DEF;
        hi_ff <= srm_pkg::LIM_HI_DEF;
        lo_en_ff <= 1'b0;
        hi_en_ff <= 1'b0;
      end else if (frst_w) begin
        temp_ff[g] <= 1'b0;
        unit_ff[g] <= srm_pkg::UNIT_C;
        lo_ff <= srm_pkg::LIM_LO_DEF;
        hi_ff <= srm_pkg::LIM_HI_DEF;
        lo_en_ff <= 1'b0;
        hi_en_ff <= 1'b0;
      end else begin
        if (cfg_ok_w & hit(cfg_ch_i, g)) begin
          temp_ff[g] <= cfg_temp_i;
          unit_ff[g] <= srm_pkg::UNIT_C;
        end
        if (unit_ok_w & hit(unit_ch_i, g)) unit_ff[g] <= unit_i;
        if (lim_ok_w & hit(lim_ch_i, g) & lim_upper_i) hi_ff <= lim_val_i;
        if (lim_ok_w & hit(lim_ch_i, g) & ~lim_upper_i) lo_ff <= lim_val_i;
        if (lim_en_wr_i & hit(lim_ch_i, g) & lim_upper_i) hi_en_ff <= lim_en_i;
        if (lim_en_wr_i & hit(lim_ch_i, g) & ~lim_upper_i) lo_en_ff <= lim_en_i;
      end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        sum_ff[g] <= '0;
        sq_ff[g] <= '0;
        cnt_c_ff[g] <= '0;
        min_ff[g] <= '0;
        max_ff[g] <= '0;
        min_ts_ff[g] <= '0;
        max_ts_ff[g] <= '0;
      end else if (mh_w) begin
        sum_ff[g] <= (first_w ? '0 : sum_ff[g]) + srm_pkg::SUMW'(meas_data_i);
        sq_ff[g] <= (first_w ? '0 : sq_ff[g]) + srm_pkg::SQW'(meas_data_i * meas_data_i);
        cnt_c_ff[g] <= first_w ? 32'h00000001 : cnt_c_ff[g] + 1'b1;
        if (first_w | meas_data_i < min_ff[g]) begin
          min_ff[g] <= meas_data_i;
          min_ts_ff[g] <= ts_ff;
        end
        if (first_w | meas_data_i > max_ff[g]) begin
          max_ff[g] <= meas_data_i;
          max_ts_ff[g] <= ts_ff;
        end
      end else if (sclr_w) begin
        sum_ff[g] <= '0;
        sq_ff[g] <= '0;
        cnt_c_ff[g] <= '0;
        min_ff[g] <= '0;
        max_ff[g] <= '0;
      end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) alm_ff[g] <= 1'b0;
      else if (mh_w & ((lo_en_ff & meas_data_i < lo_ff) | (hi_en_ff & meas_data_i > hi_ff)))
        alm_ff[g] <= 1'b1;
      else if (clr_all_w) alm_ff[g] <= 1'b0;
    end
  end

  // channel g feeds alarm g modulo four
  wire [srm_pkg::NALM-1:0] alm_grp_w = alm_ff[srm_pkg::NALM-1:0] | alm_ff[NCH-1:srm_pkg::NALM];

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alarm_ff <= '0;
      st_sum_ff <= '0;
      st_sq_ff <= '0;
      st_cnt_ff <= '0;
      st_min_ff <= '0;
      st_max_ff <= '0;
      st_ptp_ff <= '0;
      st_min_ts_ff <= '0;
      st_max_ts_ff <= '0;
      st_unit_ff <= srm_pkg::UNIT_C;
    end else begin
      alarm_ff <= alm_grp_w;
      st_sum_ff <= sum_ff[st_ch_i];
      st_sq_ff <= sq_ff[st_ch_i];
      st_cnt_ff <= cnt_c_ff[st_ch_i];
      st_min_ff <= min_ff[st_ch_i];
      st_max_ff <= max_ff[st_ch_i];
      st_ptp_ff <= srm_pkg::RDW'(max_ff[st_ch_i] - min_ff[st_ch_i]);
      st_min_ts_ff <= min_ts_ff[st_ch_i];
      st_max_ts_ff <= max_ts_ff[st_ch_i];
      st_unit_ff <= unit_ff[st_ch_i];
    end
  end

  always_comb begin
    ques_cond_o = '0;
    ques_cond_o[srm_pkg::QOVF_BIT] = ovf_ff;
  end

  assign trg_state_o = trg_ff;
  assign busy_o = eng_ff != srm_pkg::ENG_IDLE;
  assign mem_count_o = cnt_ff;
  assign err_o = err_ff;
  assign meter_on_o = meter_on_ff;
  assign fact_rst_o = frst_ff;
  assign alarm_o = alarm_ff;
  assign st_sum_o = st_sum_ff;
  assign st_sq_o = st_sq_ff;
  assign st_cnt_o = st_cnt_ff;
  assign st_min_o = st_min_ff;
  assign st_max_o = st_max_ff;
  assign st_ptp_o = st_ptp_ff;
  assign st_min_ts_o = st_min_ts_ff;
  assign st_max_ts_o = st_max_ts_ff;
  assign st_unit_o = st_unit_ff;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence arm_s;
    arm_w ##1 trg_ff == srm_pkg::TRG_WAIT;
  endsequence
  sequence go_s;
    trg_ff == srm_pkg::TRG_WAIT && trig_hit_w && !cmd_abort_i && !frst_w;
  endsequence

  abort_to_idle_a: assert property (cmd_abort_i |=> idle_w)
    else $error("abort left trigger busy");
  fetch_keeps_mem_a: assert property (push_w && !dest_ff && !clr_all_w |=> cnt_ff == $past(cnt_ff))
    else $error("copy-out changed memory");
  mem_cap_a: assert property (cnt_ff <= DEPTH)
    else $error("memory count above depth");
  ovw_keeps_full_a: assert property (ovw_w && !clr_all_w |=> ovf_ff && cnt_ff == DEPTH)
    else $error("overwrite lost fill or flag");
  arm_clears_a: assert property (arm_s |-> cnt_ff == '0 && alm_ff == '0 && !ovf_ff)
    else $error("arm did not clear memory");
  trig_start_a: assert property (go_s |=> run_w)
    else $error("trigger did not start scan");
  cfg_reject_a: assert property (cfg_wr_i && !idle_w && !frst_w
                                 |=> err_o && temp_ff == $past(temp_ff))
    else $error("busy config not flagged");
  meter_reset_a: assert property (frst_w |=> fact_rst_o && idle_w && trig_src_ff == 1'b0)
    else $error("meter change did not reset");
  rm_nowait_a: assert property (rm_take_w |=> eng_ff == srm_pkg::ENG_HDR
                                && left_ff <= $past(cnt_ff))
    else $error("destructive read stalled");
  hdr_text_a: assert property (push_w && eng_ff == srm_pkg::ENG_HDR
                               |-> fin_w[31:16] == {srm_pkg::HDR_HASH, srm_pkg::HDR_TWO})
    else $error("block header malformed");
endmodule // srm_scan_mem

/* testbench/srm_host_sink.sv */
// host side model draining the readout stream with stalls
`timescale 1ns/1ps
module srm_host_sink (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic out_vld_i,
  output logic out_rdy_o
);
  logic [1:0] stall_ff;
  // ready half the time so the fifo backs up
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) stall_ff <= 2'h0;
    else stall_ff <= stall_ff + {1'b0, out_vld_i};
  end
  assign out_rdy_o = stall_ff[1];
endmodule // srm_host_sink

/* testbench/tb.sv */
// bench for scan control and reading memory
`timescale 1ns/1ps
module tb;
  logic mclk_i, reset_n_i, cmd_abort_i, cmd_arm_i, cmd_fetch_i, cmd_read_i, cmd_remove_i;
  logic rm_all_i, trig_src_wr_i, trig_src_ext_i, trg_bus_i, trig_pin_i, meas_vld_i;
  logic scan_end_i, cfg_wr_i, cfg_temp_i, unit_wr_i, lim_wr_i, lim_en_wr_i, lim_upper_i;
  logic lim_en_i, meter_set_i, meter_val_i, st_clr_i, out_vld_o, out_rdy_i, busy_o, err_o;
  logic meter_on_o, fact_rst_o;
  logic [16:0] rm_cnt_i, mem_count_o;
  logic [2:0] meas_ch_i, cfg_ch_i, unit_ch_i, lim_ch_i, st_ch_i, trg_state_o;
  logic signed [31:0] meas_data_i, lim_val_i, st_min_o, st_max_o;
  logic [1:0] unit_i, st_unit_o;
  logic [7:0] st_clr_mask_i;
  logic [83:0] out_data_o;
  logic [15:0] ques_cond_o;
  logic [3:0] alarm_o;
  logic signed [63:0] st_sum_o;
  logic [95:0] st_sq_o;
  logic [31:0] st_cnt_o, st_ptp_o, seed, cnt0;
  logic [47:0] st_min_ts_o, st_max_ts_o;
  logic [127:0] ex;
  logic [83:0] got[$];
  logic [34:0] sent[$];
  int mismatches, num_checks;
  srm_scan_mem #(.MS_CYC_P(4)) dut (.mclk_i, .reset_n_i, .cmd_abort_i, .cmd_arm_i,
    .cmd_fetch_i, .cmd_read_i, .cmd_remove_i, .rm_all_i, .rm_cnt_i, .trig_src_wr_i,
    .trig_src_ext_i, .trg_bus_i, .trig_pin_i, .meas_vld_i, .meas_ch_i, .meas_data_i,
    .scan_end_i, .cfg_wr_i, .cfg_ch_i, .cfg_temp_i, .unit_wr_i, .unit_ch_i, .unit_i,
    .lim_wr_i, .lim_en_wr_i, .lim_upper_i, .lim_ch_i, .lim_val_i, .lim_en_i, .meter_set_i,
    .meter_val_i, .st_clr_i, .st_clr_mask_i, .st_ch_i, .out_vld_o, .out_rdy_i, .out_data_o,
    .trg_state_o, .busy_o, .mem_count_o, .ques_cond_o, .err_o, .meter_on_o, .fact_rst_o,
    .alarm_o, .st_sum_o, .st_sq_o, .st_cnt_o, .st_min_o, .st_max_o, .st_ptp_o,
    .st_min_ts_o, .st_max_ts_o, .st_unit_o);
  srm_host_sink host (.mclk_i, .reset_n_i, .out_vld_i(out_vld_o), .out_rdy_o(out_rdy_i));
  always @(posedge mclk_i) if (out_vld_o === 1'b1 && out_rdy_i) got.push_back(out_data_o);
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic chk(logic [83:0] g, logic [83:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] hdr(int n);
    int l;
    l = (n == 0) ? 0 : ((16 * n - 1 > 99) ? 99 : 16 * n - 1);
    return {8'h23, 8'h32, 8'h30 + 8'(l / 10), 8'h30 + 8'(l % 10)};
  endfunction
  // sum, minimum and maximum of channel 0 readings held
  function automatic logic [127:0] stat0();
    logic signed [63:0] s;
    logic signed [31:0] mn, mx;
    int k;
    s = '0;
    mn = '0;
    mx = '0;
    k = 0;
    foreach (sent[i]) begin
      if (sent[i][34:32] == 3'h0) begin
        if (k == 0 || $signed(sent[i][31:0]) < mn) mn = sent[i][31:0];
        if (k == 0 || $signed(sent[i][31:0]) > mx) mx = sent[i][31:0];
        s += $signed(sent[i][31:0]);
        k++;
      end
    end
    return {s, mn, mx};
  endfunction
  // readings held back to back, first one a hand-picked alarm hit
  task automatic rdg(int n);
    meas_vld_i = 1'b1;
    for (int i = 0; i < n; i++) begin
      meas_ch_i = (i == 0) ? 3'h0 : rnd() % 8;
      meas_data_i = (i == 0) ? 32'h000000C8 : rnd();
      if (meas_ch_i == 3'h0) cnt0++;
      sent.push_back({meas_ch_i, meas_data_i});
      cyc(1);
    end
    meas_vld_i = 1'b0;
  endtask
  task automatic wt(int k);
    int i;
    i = 0;
    while (got.size() < k && i < 300) begin
      cyc(1);
      i++;
    end
  endtask
  // header then n readings, popped from sent when pop is set
  task automatic drain(int n, bit h, bit pop);
    wt(n + h);
    if (h) chk({got[0][83], got[0][31:0]}, {1'b1, hdr(n)});
    for (int i = 0; i < n; i++) begin
      chk({got[i + h][82:80], got[i + h][31:0]}, sent[i]);
    end
    if (pop) repeat (n) void'(sent.pop_front());
    got.delete();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(25 * 6000);
    mismatches++;
    complete_run();
  end
  initial begin
    {cmd_abort_i, cmd_arm_i, cmd_fetch_i, cmd_read_i, cmd_remove_i, rm_all_i, trig_src_wr_i,
     trig_src_ext_i, trg_bus_i, trig_pin_i, meas_vld_i, scan_end_i, cfg_wr_i, cfg_temp_i,
     unit_wr_i, lim_wr_i, lim_en_wr_i, lim_upper_i, lim_en_i, meter_set_i, meter_val_i,
     st_clr_i, rm_cnt_i, meas_ch_i, cfg_ch_i, unit_ch_i, lim_ch_i, st_ch_i, meas_data_i,
     lim_val_i, unit_i, st_clr_mask_i, cnt0, mismatches, num_checks} = '0;
    seed = 32'h0000FDC3;
    reset_n_i = 1'b0;
    cyc(8);
    reset_n_i = 1'b1;
    lim_upper_i = 1'b1;
    lim_val_i = 32'h00000064;
    pulse(lim_wr_i);
    lim_en_i = 1'b1;
    pulse(lim_en_wr_i);
    unit_ch_i = 3'h2;
    unit_i = srm_pkg::UNIT_F;
    pulse(unit_wr_i);
    chk(err_o, 1'b1);
    cfg_ch_i = 3'h2;
    cfg_temp_i = 1'b1;
    pulse(cfg_wr_i);
    pulse(unit_wr_i);
    st_ch_i = 3'h2;
    cyc(1);
    chk({err_o, st_unit_o}, {1'b0, srm_pkg::UNIT_F});
    st_ch_i = 3'h0;
    pulse(cmd_arm_i);
    chk({trg_state_o, mem_count_o}, {3'h2, 17'h0});
    pulse(cfg_wr_i);
    chk(err_o, 1'b1);
    pulse(trg_bus_i);
    chk(trg_state_o, 3'h4);
    rdg(5);
    cyc(2);
    chk({alarm_o[0], mem_count_o}, {1'b1, 17'h5});
    chk(st_cnt_o, cnt0);
    ex = stat0();
    chk($unsigned(st_sum_o), ex[127:64]);
    chk({st_min_o, st_max_o}, ex[63:0]);
    chk(st_ptp_o, 32'(ex[31:0] - ex[63:32]));
    chk(ques_cond_o, 16'h0);
    st_clr_mask_i = 8'h01;
    pulse(st_clr_i);
    cyc(1);
    chk(st_cnt_o, 32'h0);
    rm_cnt_i = 17'h2;
    pulse(cmd_remove_i);
    chk(busy_o, 1'b1);
    drain(2, 1, 1);
    chk(mem_count_o, 17'h3);
    pulse(scan_end_i);
    chk(trg_state_o, 3'h1);
    pulse(cmd_fetch_i);
    drain(3, 0, 0);
    chk(mem_count_o, 17'h3);
    rm_cnt_i = 17'h9;
    pulse(cmd_remove_i);
    drain(3, 1, 1);
    chk(mem_count_o, 17'h0);
    trig_src_ext_i = 1'b1;
    pulse(trig_src_wr_i);
    pulse(cmd_arm_i);
    cyc(1);
    chk(alarm_o, 4'h0);
    pulse(trig_pin_i);
    cyc(2);
    chk(trg_state_o, 3'h4);
    pulse(cmd_abort_i);
    chk(trg_state_o, 3'h1);
    rdg(1);
    sent.delete();
    chk(mem_count_o, 17'h0);
    meter_val_i = 1'b1;
    pulse(meter_set_i);
    chk({fact_rst_o, meter_on_o}, 2'h3);
    pulse(cmd_read_i);
    pulse(trg_bus_i);
    rdg(2);
    pulse(scan_end_i);
    drain(2, 0, 1);
    complete_run();
  end
endmodule // tb
